// ==== rtl/ctp_top.sv ====
// time base, time stamp capture, pending flags and transmit priority scan
// assumes protocol engines give one-cycle event pulses synchronous to i_mclk
//
// Behaviour
// - one module clock drives everything
// - prescaler register divides the time-base clock
// - 16-bit free-running counter feeds all captures
// - each event group drives its own bundled request line
// - pending flags latch until software clears
// - global and two module pending registers
// - read-only summary mirrors flags, writes ignored
// - capture counter when received frame is valid
// - store capture in accepting buffer stamp field
// - errored reception leaves stamp undefined
// - capture counter at transmit start of frame
// - stamp replaces last two data bytes
// - buffer is transmit or receive with mask; here only the C_TX bit, no mask field
// - scan pending transmit buffers before each send
// - never send lower priority frame first
module ctp_top #(
	parameter int GLOB_W = 8,
	parameter int MOD_W  = 8
) (
	// clock and reset
	input  wire logic                                    i_mclk,
	input  wire logic                                    i_sys_rst,
	// register port
	input  wire logic [ctp_pkg::ADDR_W-1:0]              i_addr,
	input  wire logic [ctp_pkg::DATA_W-1:0]              i_wdata,
	input  wire logic                                    i_wr,
	input  wire logic                                    i_rd,
	output logic      [ctp_pkg::DATA_W-1:0]              o_rdata,
	// interrupt events and bundled lines
	input  wire logic [GLOB_W-1:0]                       i_glob_evt,
	input  wire logic [MOD_W-1:0]                        i_mod1_evt,
	input  wire logic [MOD_W-1:0]                        i_mod2_evt,
	output logic                                         o_irq_glob,
	output logic                                         o_irq_mod1,
	output logic                                         o_irq_mod2,
	// reception from the protocol engines
	input  wire logic [ctp_pkg::NMOD-1:0]                i_rx_ok,
	input  wire logic [ctp_pkg::NMOD-1:0][ctp_pkg::BUF_IDX_W-1:0] i_rx_buf,
	// transmission handshake with the protocol engines
	input  wire logic [ctp_pkg::NMOD-1:0]                i_tx_req,
	input  wire logic [ctp_pkg::NMOD-1:0]                i_tx_sof,
	input  wire logic [ctp_pkg::NMOD-1:0]                i_tx_done,
	output logic      [ctp_pkg::NMOD-1:0]                o_tx_valid,
	output logic      [ctp_pkg::NMOD-1:0][ctp_pkg::BUF_IDX_W-1:0] o_tx_buf,
	output logic      [ctp_pkg::NMOD-1:0][ctp_pkg::ID_W-1:0]      o_tx_id,
	output logic      [ctp_pkg::NMOD-1:0][ctp_pkg::DLC_W-1:0]     o_tx_dlc,
	output logic      [ctp_pkg::NMOD-1:0][ctp_pkg::NBYTES*ctp_pkg::BYTE_W-1:0] o_tx_data,
	// time base
	output logic      [ctp_pkg::TS_W-1:0]                o_time
);
	localparam int IW = ctp_pkg::BUF_IDX_W;
	localparam int DW = ctp_pkg::NBYTES * ctp_pkg::BYTE_W;
	localparam int BW = ctp_pkg::BYTE_W;

	logic [ctp_pkg::PRESC_W-1:0] presc_cfg;
	logic [ctp_pkg::PRESC_W-1:0] next_presc_cfg;
	logic [ctp_pkg::PRESC_W-1:0] presc_cnt;
	logic [ctp_pkg::PRESC_W-1:0] next_presc_cnt;
	logic [ctp_pkg::TS_W-1:0]    time_cnt;
	logic [ctp_pkg::TS_W-1:0]    next_time_cnt;
	logic                        tick;
	logic [GLOB_W-1:0]           gpend;
	logic [GLOB_W-1:0]           next_gpend;
	logic [MOD_W-1:0]            m1pend;
	logic [MOD_W-1:0]            next_m1pend;
	logic [MOD_W-1:0]            m2pend;
	logic [MOD_W-1:0]            next_m2pend;
	logic [ctp_pkg::DATA_W-1:0]  next_rdata;
	logic [ctp_pkg::DATA_W-1:0]  buf_conf [ctp_pkg::NBUF];
	logic [ctp_pkg::DATA_W-1:0]  next_buf_conf [ctp_pkg::NBUF];
	logic [ctp_pkg::ID_W-1:0]    buf_id [ctp_pkg::NBUF];
	logic [ctp_pkg::ID_W-1:0]    next_buf_id [ctp_pkg::NBUF];
	logic [DW-1:0]               buf_data [ctp_pkg::NBUF];
	logic [DW-1:0]               next_buf_data [ctp_pkg::NBUF];
	logic [ctp_pkg::TS_W-1:0]    buf_time [ctp_pkg::NBUF];
	logic [ctp_pkg::TS_W-1:0]    next_buf_time [ctp_pkg::NBUF];
	logic [ctp_pkg::NMOD-1:0]    next_tx_valid;
	logic [ctp_pkg::NMOD-1:0][IW-1:0]              next_tx_buf;
	logic [ctp_pkg::NMOD-1:0][ctp_pkg::ID_W-1:0]   next_tx_id;
	logic [ctp_pkg::NMOD-1:0][ctp_pkg::DLC_W-1:0]  next_tx_dlc;
	logic [ctp_pkg::NMOD-1:0][DW-1:0]              next_tx_data;
	logic [ctp_pkg::ADDR_W-1:0]  boff;
	logic                        is_buf;
	logic [IW-1:0]               bidx;
	logic [ctp_pkg::FLD_W-1:0]   fld;

	// buffer waiting to go out on the given module
	function automatic logic tx_pending(input int b, input logic mod);
		return buf_conf[b][ctp_pkg::C_TX] && buf_conf[b][ctp_pkg::C_TXREQ]
			&& (buf_conf[b][ctp_pkg::C_LINK] == mod);
	endfunction : tx_pending

	// lowest identifier wins, equal ids go to the lower buffer number
	function automatic logic [IW:0] scan_best(input logic mod);
		logic                     found;
		logic [IW-1:0]            best;
		logic [ctp_pkg::ID_W-1:0] best_id;
		found   = 1'b0;
		best    = '0;
		best_id = '1;
		for (int b = 0; b < ctp_pkg::NBUF; b++) begin
			if (tx_pending(b, mod) && (!found || buf_id[b] < best_id)) begin
				found   = 1'b1;
				best    = IW'(b);
				best_id = buf_id[b];
			end
		end
		return {found, best};
	endfunction : scan_best

	// lay out bus bytes, last two replaced by the captured stamp
	function automatic logic [DW-1:0] stamp_data(input logic [DW-1:0] d,
			input logic [ctp_pkg::DLC_W-1:0] dlc, input logic auto_stamp,
			input logic [ctp_pkg::TS_W-1:0] ts);
		logic [DW-1:0] r;
		int            n;
		r = '0;
		n = (int'(dlc) > ctp_pkg::NBYTES) ? ctp_pkg::NBYTES : int'(dlc);
		for (int i = 0; i < ctp_pkg::NBYTES; i++) begin
			if (i < n)
				r[i*BW +: BW] = d[i*BW +: BW];
			if (auto_stamp && n >= 2 && i == n - 2)
				r[i*BW +: BW] = ts[BW-1:0];
			if (auto_stamp && n >= 2 && i == n - 1)
				r[i*BW +: BW] = ts[ctp_pkg::TS_W-1:BW];
		end
		return r;
	endfunction : stamp_data

	// address split for the buffer window
	assign boff   = i_addr - ctp_pkg::A_BUF_BASE;
	assign is_buf = (i_addr >= ctp_pkg::A_BUF_BASE)
		&& (boff < ctp_pkg::ADDR_W'(ctp_pkg::NBUF << ctp_pkg::FLD_W));
	assign bidx   = boff[ctp_pkg::FLD_W +: IW];
	assign fld    = boff[ctp_pkg::FLD_W-1:0];
	assign tick   = (presc_cnt == presc_cfg);

	// time base: divider by presc_cfg+1, then a wrapping counter
	always_comb begin
		next_presc_cfg = presc_cfg;
		if (i_wr && i_addr == ctp_pkg::A_PRESC)
			next_presc_cfg = i_wdata[ctp_pkg::PRESC_W-1:0];
		next_presc_cnt = tick ? '0 : presc_cnt + 1'b1;
		next_time_cnt  = tick ? time_cnt + 1'b1 : time_cnt;
	end

	// set wins over a clear in the same cycle so no event is lost
	always_comb begin
		next_gpend  = gpend | i_glob_evt;
		next_m1pend = m1pend | i_mod1_evt;
		next_m2pend = m2pend | i_mod2_evt;
		if (i_wr && i_addr == ctp_pkg::A_GPEND)
			next_gpend = (gpend & ~i_wdata[GLOB_W-1:0]) | i_glob_evt;
		if (i_wr && i_addr == ctp_pkg::A_M1PEND)
			next_m1pend = (m1pend & ~i_wdata[MOD_W-1:0]) | i_mod1_evt;
		if (i_wr && i_addr == ctp_pkg::A_M2PEND)
			next_m2pend = (m2pend & ~i_wdata[MOD_W-1:0]) | i_mod2_evt;
		// the summary address takes no write at all
	end

	// read mux, data stand in the cycle after the strobe only
	always_comb begin
		next_rdata = '0;
		if (i_rd) begin
			unique case (i_addr)
				ctp_pkg::A_PRESC:   next_rdata = 32'(presc_cfg);
				ctp_pkg::A_TIME:    next_rdata = 32'(time_cnt);
				ctp_pkg::A_GPEND:   next_rdata = 32'(gpend);
				ctp_pkg::A_M1PEND:  next_rdata = 32'(m1pend);
				ctp_pkg::A_M2PEND:  next_rdata = 32'(m2pend);
				ctp_pkg::A_SUMMARY: next_rdata = 32'({m2pend, m1pend, gpend});
				default: begin
					if (is_buf) begin
						unique case (fld)
							ctp_pkg::F_CONF: next_rdata = buf_conf[bidx];
							ctp_pkg::F_ID:   next_rdata = 32'(buf_id[bidx]);
							ctp_pkg::F_DLO:  next_rdata = buf_data[bidx][ctp_pkg::DATA_W-1:0];
							ctp_pkg::F_DHI:  next_rdata = buf_data[bidx][DW-1:ctp_pkg::DATA_W];
							ctp_pkg::F_TIME: next_rdata = 32'(buf_time[bidx]);
							default:         next_rdata = '0;
						endcase
					end
				end
			endcase
		end
	end

	// buffers, captures and transmit selection
	always_comb begin
		logic [IW:0] pick;
		pick          = '0;
		next_buf_conf = buf_conf;
		next_buf_id   = buf_id;
		next_buf_data = buf_data;
		next_buf_time = buf_time;
		next_tx_valid = o_tx_valid;
		next_tx_buf   = o_tx_buf;
		next_tx_id    = o_tx_id;
		next_tx_dlc   = o_tx_dlc;
		next_tx_data  = o_tx_data;
		// software sets link, type, stamping, length and request freely
		if (i_wr && is_buf) begin
			unique case (fld)
				ctp_pkg::F_CONF: next_buf_conf[bidx] = i_wdata & ctp_pkg::CONF_MASK;
				ctp_pkg::F_ID:   next_buf_id[bidx]   = i_wdata[ctp_pkg::ID_W-1:0];
				ctp_pkg::F_DLO:  next_buf_data[bidx][ctp_pkg::DATA_W-1:0] = i_wdata;
				ctp_pkg::F_DHI:  next_buf_data[bidx][DW-1:ctp_pkg::DATA_W] = i_wdata;
				ctp_pkg::F_TIME: next_buf_time[bidx] = i_wdata[ctp_pkg::TS_W-1:0];
				default: begin
				end
			endcase
		end
		for (int m = 0; m < ctp_pkg::NMOD; m++) begin
			// only a valid frame pulses i_rx_ok, errored frames never write
			if (i_rx_ok[m])
				next_buf_time[i_rx_buf[m]] = time_cnt;
			if (i_tx_req[m]) begin
				pick             = scan_best(m[0]);
				next_tx_valid[m] = pick[IW];
				next_tx_buf[m]   = pick[IW-1:0];
				next_tx_id[m]    = buf_id[pick[IW-1:0]];
				next_tx_dlc[m]   = buf_conf[pick[IW-1:0]][ctp_pkg::C_DLC_LO +: ctp_pkg::DLC_W];
			end else if (i_tx_sof[m] && o_tx_valid[m]) begin
				next_tx_data[m] = stamp_data(buf_data[o_tx_buf[m]], o_tx_dlc[m],
					buf_conf[o_tx_buf[m]][ctp_pkg::C_AUTO_STAMP], time_cnt);
			end else if (i_tx_done[m] && o_tx_valid[m]) begin
				next_tx_valid[m] = 1'b0;
				next_buf_conf[o_tx_buf[m]][ctp_pkg::C_TXREQ] = 1'b0;
			end
		end
	end

	// single module clock for every flop
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			presc_cfg  <= ctp_pkg::PRESC_RST;
			presc_cnt  <= '0;
			time_cnt   <= '0;
			gpend      <= '0;
			m1pend     <= '0;
			m2pend     <= '0;
			o_irq_glob <= 1'b0;
			o_irq_mod1 <= 1'b0;
			o_irq_mod2 <= 1'b0;
			o_rdata    <= '0;
			o_time     <= '0;
			buf_conf   <= '{default: '0};
			buf_id     <= '{default: '0};
			buf_data   <= '{default: '0};
			buf_time   <= '{default: '0};
			o_tx_valid <= '0;
			o_tx_buf   <= '0;
			o_tx_id    <= '0;
			o_tx_dlc   <= '0;
			o_tx_data  <= '0;
		end else begin
			presc_cfg  <= next_presc_cfg;
			presc_cnt  <= next_presc_cnt;
			time_cnt   <= next_time_cnt;
			gpend      <= next_gpend;
			m1pend     <= next_m1pend;
			m2pend     <= next_m2pend;
			o_irq_glob <= |next_gpend;
			o_irq_mod1 <= |next_m1pend;
			o_irq_mod2 <= |next_m2pend;
			o_rdata    <= next_rdata;
			o_time     <= next_time_cnt;
			buf_conf   <= next_buf_conf;
			buf_id     <= next_buf_id;
			buf_data   <= next_buf_data;
			buf_time   <= next_buf_time;
			o_tx_valid <= next_tx_valid;
			o_tx_buf   <= next_tx_buf;
			o_tx_id    <= next_tx_id;
			o_tx_dlc   <= next_tx_dlc;
			o_tx_data  <= next_tx_data;
		end
	end

	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	// helper: some pending buffer on module 0 beats the chosen one
	logic inv0;
	always_comb begin
		inv0 = 1'b0;
		for (int b = 0; b < ctp_pkg::NBUF; b++)
			if (tx_pending(b, 1'b0) && buf_id[b] < o_tx_id[0])
				inv0 = 1'b1;
	end

	sequence s_scan0;
		i_tx_req[0] && !i_wr;
	endsequence
	sequence s_sof8;
		i_tx_sof[0] && !i_tx_req[0] && o_tx_valid[0] && o_tx_dlc[0] == 4'h8
			&& buf_conf[o_tx_buf[0]][ctp_pkg::C_AUTO_STAMP];
	endsequence

	a_time_step: assert property (tick |=> time_cnt == 16'($past(time_cnt) + 1'b1))
		else $error("time counter did not advance on tick");
	a_time_hold: assert property (!tick |=> $stable(time_cnt))
		else $error("time counter moved without tick");
	// every set global flag survives a cycle that has no clear aimed at it
	a_pend_latch: assert property ((|gpend && !(i_wr && i_addr == ctp_pkg::A_GPEND))
		|=> (gpend & $past(gpend)) == $past(gpend))
		else $error("pending flag dropped without a clear");
	// an event meeting its own clear must still leave the flag set
	a_set_wins: assert property ((i_glob_evt != '0)
		|=> (gpend & $past(i_glob_evt)) == $past(i_glob_evt))
		else $error("event lost against a clear");
	a_summary_nowrite: assert property ((i_wr && i_addr == ctp_pkg::A_SUMMARY)
		|=> (gpend & $past(gpend)) == $past(gpend)
		&& (m1pend & $past(m1pend)) == $past(m1pend)
		&& (m2pend & $past(m2pend)) == $past(m2pend))
		else $error("summary write cleared a flag");
	a_irq_bundle: assert property (o_irq_glob == |gpend && o_irq_mod1 == |m1pend
		&& o_irq_mod2 == |m2pend)
		else $error("bundled line disagrees with flags");
	a_rx_stamp: assert property ((i_rx_ok[0] && !i_rx_ok[1] && !(i_wr && is_buf))
		|=> buf_time[$past(i_rx_buf[0])] == $past(time_cnt))
		else $error("reception stamp not captured");
	// module 1 is applied last, so it owns a buffer that both engines hit
	a_rx_stamp_mod1: assert property ((i_rx_ok[1] && !(i_wr && is_buf))
		|=> buf_time[$past(i_rx_buf[1])] == $past(time_cnt))
		else $error("module 1 reception stamp not captured");
	a_scan_pick: assert property (s_scan0 |=> !o_tx_valid[0] || tx_pending(o_tx_buf[0], 1'b0))
		else $error("selected buffer not pending on module");
	a_no_inversion: assert property (s_scan0 |=> !o_tx_valid[0] || !inv0)
		else $error("lower priority frame selected");
	a_sof_stamp: assert property (s_sof8 |=> o_tx_data[0][DW-1:DW-ctp_pkg::TS_W]
		== {$past(time_cnt[ctp_pkg::TS_W-1:BW]), $past(time_cnt[BW-1:0])})
		else $error("stamp bytes wrong at start of frame");
	// a finished frame gives up its request so it never goes out twice
	a_tx_release: assert property ((i_tx_done[0] && !i_tx_req[0] && !i_tx_sof[0]
		&& o_tx_valid[0])
		|=> !o_tx_valid[0] && !buf_conf[$past(o_tx_buf[0])][ctp_pkg::C_TXREQ])
		else $error("finished frame still requested");
endmodule : ctp_top

// ==== include/ctp_pkg.sv ====
// constants for the time stamp, pending flag and buffer scan block
// assumes a word register port with a 9-bit word address
package ctp_pkg;
	// widths
	localparam int ADDR_W    = 9;
	localparam int DATA_W    = 32;
	localparam int TS_W      = 16;
	localparam int PRESC_W   = 8;
	localparam int ID_W      = 11;
	localparam int DLC_W     = 4;
	localparam int BYTE_W    = 8;
	localparam int NBYTES    = 8;
	localparam int NMOD      = 2;
	localparam int NBUF      = 32;
	localparam int BUF_IDX_W = 5;
	localparam int FLD_W     = 3;
	// global register word addresses
	localparam logic [ADDR_W-1:0] A_PRESC    = 9'h000;
	localparam logic [ADDR_W-1:0] A_TIME     = 9'h001;
	localparam logic [ADDR_W-1:0] A_GPEND    = 9'h002;
	localparam logic [ADDR_W-1:0] A_M1PEND   = 9'h003;
	localparam logic [ADDR_W-1:0] A_M2PEND   = 9'h004;
	localparam logic [ADDR_W-1:0] A_SUMMARY  = 9'h005;
	localparam logic [ADDR_W-1:0] A_BUF_BASE = 9'h100;
	// per-buffer word index inside its eight-word slot
	localparam logic [FLD_W-1:0] F_CONF = 3'h0;
	localparam logic [FLD_W-1:0] F_ID   = 3'h1;
	localparam logic [FLD_W-1:0] F_DLO  = 3'h2;
	localparam logic [FLD_W-1:0] F_DHI  = 3'h3;
	localparam logic [FLD_W-1:0] F_TIME = 3'h4;
	// buffer configuration word fields
	localparam int C_LINK       = 0;
	localparam int C_TX         = 1;
	localparam int C_AUTO_STAMP = 4;
	localparam int C_DLC_LO     = 8;
	localparam int C_TXREQ      = 16;
	localparam logic [DATA_W-1:0] CONF_MASK = 32'h0001_0F1F;
	// reset values
	localparam logic [PRESC_W-1:0] PRESC_RST = 8'h00;
endpackage : ctp_pkg

// ==== tb/ctp_engine.sv ====
// protocol engine model: frame valid, transmit start, sof and done pulses
// assumes the bench calls pulse from one process only
module ctp_engine (
	// clock
	input  wire logic                                             i_mclk,
	// event pulses towards the block
	output logic      [ctp_pkg::NMOD-1:0]                         o_rx_ok,
	output logic      [ctp_pkg::NMOD-1:0][ctp_pkg::BUF_IDX_W-1:0] o_rx_buf,
	output logic      [ctp_pkg::NMOD-1:0]                         o_tx_req,
	output logic      [ctp_pkg::NMOD-1:0]                         o_tx_sof,
	output logic      [ctp_pkg::NMOD-1:0]                         o_tx_done
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle: no pulses, buffer index holds garbage
	initial begin
		o_rx_ok = '0;
		o_rx_buf = '1;
		o_tx_req = '0;
		o_tx_sof = '0;
		o_tx_done = '0;
	end

	// kind 0 valid frame, 1 transmit start, 2 sof, 3 done; gap models a slow engine
	task automatic pulse(input int kind, input int m, input int b, input int gap);
		repeat (gap) @(posedge i_mclk);
		@(posedge i_mclk);
		case (kind)
			0: o_rx_ok[m] <= 1'b1;
			1: o_tx_req[m] <= 1'b1;
			2: o_tx_sof[m] <= 1'b1;
			default: o_tx_done[m] <= 1'b1;
		endcase
		o_rx_buf[m] <= 5'(b);
		@(posedge i_mclk);
		o_rx_ok <= '0;
		o_tx_req <= '0;
		o_tx_sof <= '0;
		o_tx_done <= '0;
		// index no longer qualified, so show its inverse
		o_rx_buf[m] <= ~5'(b);
		@(posedge i_mclk);
		#1;
	endtask : pulse
endmodule : ctp_engine

// ==== tb/ctp_top_test.sv ====
// self-checking bench: time base, pending flags, stamps, transmit scan
// assumes ctp_engine stands in for both protocol engines
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("unexpected at %0t: got %h expected %h", $time, g, e); \
	end \
end
module ctp_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic                                             i_mclk = 1'b0;
	logic                                             i_sys_rst;
	logic [8:0]                                       i_addr;
	logic [31:0]                                      i_wdata, rdata;
	logic                                             i_wr, i_rd, irq_g, irq_1, irq_2;
	logic [7:0]                                       i_glob_evt, i_mod1_evt, i_mod2_evt;
	logic [ctp_pkg::NMOD-1:0]                         rx_ok, tx_req, tx_sof, tx_done, tx_valid;
	logic [ctp_pkg::NMOD-1:0][ctp_pkg::BUF_IDX_W-1:0] rx_buf, tx_buf;
	logic [ctp_pkg::NMOD-1:0][ctp_pkg::ID_W-1:0]      tx_id;
	logic [ctp_pkg::NMOD-1:0][ctp_pkg::DLC_W-1:0]     tx_dlc;
	logic [ctp_pkg::NMOD-1:0][63:0]                   tx_data;
	logic [15:0]                                      o_time;
	int                                               error_cnt = 0, tests_run = 0, cyc = 0;

	ctp_top ctp_top_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
		.i_glob_evt(i_glob_evt), .i_mod1_evt(i_mod1_evt), .i_mod2_evt(i_mod2_evt),
		.o_irq_glob(irq_g), .o_irq_mod1(irq_1), .o_irq_mod2(irq_2), .i_rx_ok(rx_ok),
		.i_rx_buf(rx_buf), .i_tx_req(tx_req), .i_tx_sof(tx_sof), .i_tx_done(tx_done),
		.o_tx_valid(tx_valid), .o_tx_buf(tx_buf), .o_tx_id(tx_id), .o_tx_dlc(tx_dlc),
		.o_tx_data(tx_data), .o_time(o_time));
	ctp_engine ctp_engine_i (.i_mclk(i_mclk), .o_rx_ok(rx_ok), .o_rx_buf(rx_buf),
		.o_tx_req(tx_req), .o_tx_sof(tx_sof), .o_tx_done(tx_done));

	// one module clock for everything
	always #10 i_mclk = ~i_mclk;
	// hang guard: the wrap wait alone needs some 66000 cycles
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 100000) begin
			error_cnt++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask : wr

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [8:0] a, output logic [31:0] d);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 d = rdata;
	endtask : rd

	function automatic logic [8:0] ba(input int b, input logic [2:0] f);
		return ctp_pkg::A_BUF_BASE + 9'(b * 8) + 9'(f);
	endfunction : ba

	// wait for a counter step so the next 250 cycles see one value
	task automatic sync();
		logic [15:0] t;
		t = o_time;
		for (int n = 0; n < 600 && o_time === t; n++)
			@(posedge i_mclk);
		repeat (2) @(posedge i_mclk);
		#1;
	endtask : sync

	task automatic t_time();
		logic [31:0] a, b;
		rd(ctp_pkg::A_PRESC, a);
		`CHK(a[7:0], ctp_pkg::PRESC_RST)
		wr(ctp_pkg::A_PRESC, 32'h0000_0003);
		rd(ctp_pkg::A_PRESC, a);
		`CHK(a, 32'h0000_0003)
		rd(ctp_pkg::A_TIME, a);
		repeat (38) @(posedge i_mclk);
		rd(ctp_pkg::A_TIME, b);
		// forty cycles at divide-by-four is ten steps whatever the phase
		`CHK(16'(b[15:0] - a[15:0]), 16'h000A)
		wr(ctp_pkg::A_PRESC, 32'h0000_0000);
		for (int n = 0; n < 70000 && o_time !== 16'hFFFF; n++)
			@(posedge i_mclk) #1;
		@(posedge i_mclk) #1;
		`CHK(o_time, 16'h0000)
		$display("time base done");
	endtask : t_time

	task automatic t_pend();
		logic [31:0] d;
		@(posedge i_mclk);
		i_glob_evt <= 8'h08;
		i_mod1_evt <= 8'h01;
		i_mod2_evt <= 8'h80;
		@(posedge i_mclk);
		i_glob_evt <= 8'h00;
		i_mod1_evt <= 8'h00;
		i_mod2_evt <= 8'h00;
		repeat (3) @(posedge i_mclk) #1;
		`CHK({irq_2, irq_1, irq_g}, 3'b111)
		rd(ctp_pkg::A_SUMMARY, d);
		`CHK(d, 32'h0080_0108)
		wr(ctp_pkg::A_SUMMARY, 32'hFFFF_FFFF);
		rd(ctp_pkg::A_SUMMARY, d);
		`CHK(d, 32'h0080_0108)
		wr(ctp_pkg::A_GPEND, 32'h0000_0008);
		rd(ctp_pkg::A_GPEND, d);
		`CHK(d, 32'h0000_0000)
		rd(ctp_pkg::A_M1PEND, d);
		`CHK(d, 32'h0000_0001)
		`CHK({irq_2, irq_1, irq_g}, 3'b110)
		// event and clear of the same flag meet at one edge
		fork
			wr(ctp_pkg::A_GPEND, 32'h0000_0001);
			begin
				@(posedge i_mclk);
				i_glob_evt <= 8'h01;
				@(posedge i_mclk);
				i_glob_evt <= 8'h00;
			end
		join
		rd(ctp_pkg::A_GPEND, d);
		`CHK(d, 32'h0000_0001)
		wr(ctp_pkg::A_GPEND, 32'h0000_0001);
		wr(ctp_pkg::A_M1PEND, 32'h0000_0001);
		wr(ctp_pkg::A_M2PEND, 32'h0000_0080);
		rd(9'h0FF, d);
		`CHK({irq_2, irq_1, irq_g, d}, 35'h0)
		$display("pending flags done");
	endtask : t_pend

	task automatic t_rx();
		logic [31:0] d;
		logic [15:0] t;
		wr(ctp_pkg::A_PRESC, 32'h0000_00FF);
		sync();
		t = o_time;
		ctp_engine_i.pulse(0, 0, 31, 0);
		rd(ba(31, ctp_pkg::F_TIME), d);
		`CHK(d[15:0], t)
		ctp_engine_i.pulse(0, 1, 0, 3);
		rd(ba(0, ctp_pkg::F_TIME), d);
		`CHK(d[15:0], t)
		$display("receive stamp done");
	endtask : t_rx

	function automatic logic [63:0] exp_data(input int i, input int n, input logic [15:0] t);
		logic [63:0] r;
		r = '0;
		for (int k = 0; k < n - 2; k++)
			r[8*k +: 8] = 8'(16 * i + k);
		if (n == 1)
			r[7:0] = 8'(16 * i);
		else
			r[8*(n-2) +: 16] = t;
		return r;
	endfunction : exp_data

	task automatic t_tx();
		int          bn[5] = '{2, 1, 15, 22, 14};
		int          id[5] = '{'h229, 'h120, 'h023, 'h123, 'h223};
		int          dl[5] = '{3, 2, 1, 8, 5};
		int          ord[5] = '{2, 1, 3, 4, 0};
		logic [31:0] d;
		logic [15:0] t;
		// five frames on one module, so no address ordering needed
		for (int i = 0; i < 5; i++) begin
			wr(ba(bn[i], ctp_pkg::F_ID), 32'(id[i]));
			wr(ba(bn[i], ctp_pkg::F_DLO), 32'h0302_0100 + 32'h1010_1010 * i);
			wr(ba(bn[i], ctp_pkg::F_DHI), 32'h0706_0504 + 32'h1010_1010 * i);
			wr(ba(bn[i], ctp_pkg::F_CONF), 32'h0001_0012 | 32'(dl[i] << 8));
		end
		// a cheaper unstamped frame on the other bus, a receive buffer marked pending
		wr(ba(5, ctp_pkg::F_ID), 32'h0000_0001);
		wr(ba(5, ctp_pkg::F_DLO), 32'h4433_2211);
		wr(ba(5, ctp_pkg::F_CONF), 32'h0001_0803);
		wr(ba(6, ctp_pkg::F_ID), 32'h0000_0000);
		wr(ba(6, ctp_pkg::F_CONF), 32'h0001_0800);
		foreach (ord[j]) begin
			sync();
			t = o_time;
			ctp_engine_i.pulse(1, 0, 0, 0);
			`CHK({tx_valid[0], tx_buf[0]}, {1'b1, 5'(bn[ord[j]])})
			`CHK({tx_id[0], tx_dlc[0]}, {11'(id[ord[j]]), 4'(dl[ord[j]])})
			ctp_engine_i.pulse(2, 0, 0, j);
			`CHK(tx_data[0], exp_data(ord[j], dl[ord[j]], t))
			ctp_engine_i.pulse(3, 0, 0, 0);
			rd(ba(bn[ord[j]], ctp_pkg::F_CONF), d);
			`CHK({tx_valid[0], d[16]}, 2'b00)
		end
		ctp_engine_i.pulse(1, 0, 0, 0);
		`CHK(tx_valid[0], 1'b0)
		ctp_engine_i.pulse(1, 1, 0, 1);
		`CHK({tx_valid[1], tx_buf[1], tx_id[1]}, {1'b1, 5'h05, 11'h001})
		`CHK(tx_dlc[1], 4'h8)
		// stamping off: all eight stored bytes go out unchanged
		ctp_engine_i.pulse(2, 1, 0, 0);
		`CHK(tx_data[1], 64'h0000_0000_4433_2211)
		$display("transmit scan done");
	endtask : t_tx

	// reset held eight cycles, then scenarios in turn
	initial begin
		i_sys_rst = 1'b1;
		i_addr = '0;
		i_wdata = '0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_glob_evt = '0;
		i_mod1_evt = '0;
		i_mod2_evt = '0;
		repeat (8) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		t_time();
		t_pend();
		t_rx();
		t_tx();
		complete_run();
	end
endmodule : ctp_top_test
